// ---- common/pmd_pkg.sv ----
// Constants shared by the module-disable block and its gating slice
package pmd_pkg;
    // Register byte offsets on the APB bus
    localparam logic [11:0] OFF_CTRL0  = 12'h000;
    localparam logic [11:0] OFF_CTRL1  = 12'h004;
    localparam logic [11:0] OFF_STATUS = 12'h008;

    // Implemented bits; everything else reads as zero
    localparam logic [7:0] CTRL0_MASK = 8'hE5;
    localparam logic [7:0] CTRL1_MASK = 8'h17;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Field positions, first control register
    localparam int BIT_SYSCLK_GATE = 7;
    localparam int BIT_VREF        = 6;
    localparam int BIT_CLK_TUNING  = 5;
    localparam int BIT_MEMORY      = 2;
    localparam int BIT_PIN_CHANGE  = 0;

    // Field positions, second control register
    localparam int BIT_TIMER_FOUR = 4;
    localparam int BIT_TIMER_TWO  = 2;
    localparam int BIT_TIMER_ONE  = 1;
    localparam int BIT_TIMER_ZERO = 0;

    // Index of each controlled module on the gating vectors
    localparam int NUM_MODULES    = 8;
    localparam int IDX_PIN_CHANGE = 0;
    localparam int IDX_MEMORY     = 1;
    localparam int IDX_CLK_TUNING = 2;
    localparam int IDX_VREF       = 3;
    localparam int IDX_TIMER_ZERO = 4;
    localparam int IDX_TIMER_ONE  = 5;
    localparam int IDX_TIMER_TWO  = 6;
    localparam int IDX_TIMER_FOUR = 7;

    // Status register fields
    localparam int STAT_MEM_READY = 8;
    localparam int STAT_SYSCLK    = 9;

    // Timing: clock period, one instruction cycle, memory settle time
    localparam int CLK_PERIOD_PS    = 5000;
    localparam int INSTR_CYCLE_CLKS = 4;
    localparam int MEM_SETTLE_US    = 1;
    localparam int MEM_SETTLE_CYCLES =
        (MEM_SETTLE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage : pmd_pkg

// ---- common/module_gate_if.sv ----
// Per-module gating signals between the register block and the gate slice
interface module_gate_if #(parameter int N = 8);
    logic [N-1:0]   off;
    logic [N-1:0]   clk_en;
    logic [N-1:0]   reset_hold;
    logic [N-1:0]   wr_req;
    logic [N-1:0]   wr_allow;
    logic [N*8-1:0] rd_raw;
    logic [N*8-1:0] rd_safe;

    // Register block side
    modport ctrl (output off, output wr_req, output rd_raw,
                  input clk_en, input reset_hold, input wr_allow,
                  input rd_safe);
    // Gate slice side
    modport gate (input off, input wr_req, input rd_raw,
                  output clk_en, output reset_hold, output wr_allow,
                  output rd_safe);
endinterface : module_gate_if

// ---- src/module_gate.sv ----
// Per-module clock gate, reset hold, write block and read zeroing
module module_gate #(
    parameter int N       = pmd_pkg::NUM_MODULES,
    parameter int RELEASE = pmd_pkg::INSTR_CYCLE_CLKS
) (
    input wire logic    pclk,
    input wire logic    presetn,
    module_gate_if.gate g
);
    localparam int CW = $clog2(RELEASE + 1);
    localparam logic [CW-1:0] REL_LOAD = CW'(RELEASE);

    // Refused at elaboration: no window or no module leaves nothing to gate
    if (RELEASE < 1 || N < 1)
    begin : g_bad_params
        $error("module_gate: RELEASE and N must be at least one");
    end

    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_mod
            logic [CW-1:0] hold_cnt;
            logic          held;

            // Reset stays on one instruction cycle past the clear
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    hold_cnt <= '0;
                else if (g.off[i])
                    hold_cnt <= REL_LOAD;
                else if (hold_cnt != '0)
                    hold_cnt <= hold_cnt - CW'(1);
            end

            // Clock runs again at once so the reset can take hold
            assign held            = g.off[i] || (hold_cnt != '0);
            assign g.reset_hold[i] = held;
            assign g.clk_en[i]     = !g.off[i];
            assign g.wr_allow[i]   = g.wr_req[i] && !held;

            // Read data is zero while held, registered for timing
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    g.rd_safe[i*8 +: 8] <= 8'h00;
                else
                    g.rd_safe[i*8 +: 8] <= held ? 8'h00 : g.rd_raw[i*8 +: 8];
            end

            sequence s_cleared;
                $fell(g.off[i]) ##1 (!g.off[i])[*4];
            endsequence

            property p_off_stops;
                @(posedge pclk) disable iff (!presetn)
                g.off[i] |-> (!g.clk_en[i] && g.reset_hold[i]);
            endproperty
            a_off_stops: assert property (p_off_stops)
                else $error("disabled module still clocked or released");

            property p_release;
                @(posedge pclk) disable iff (!presetn)
                s_cleared |-> !g.reset_hold[i];
            endproperty
            a_release: assert property (p_release)
                else $error("module not released after one instruction");

            property p_fresh;
                @(posedge pclk) disable iff (!presetn)
                $fell(g.off[i]) |-> g.reset_hold[i];
            endproperty
            a_fresh: assert property (p_fresh)
                else $error("module left reset too early after clear");

            property p_rd_zero;
                @(posedge pclk) disable iff (!presetn)
                g.off[i] ##1 1'b1 |-> g.rd_safe[i*8 +: 8] == 8'h00;
            endproperty
            a_rd_zero: assert property (p_rd_zero)
                else $error("disabled module read not zero");
        end
    endgenerate
endmodule : module_gate

// ---- src/module_disable.sv ----
// Peripheral module disable: APB registers and per-module gating
module module_disable #(
    parameter int RELEASE_CYCLES = pmd_pkg::INSTR_CYCLE_CLKS,
    parameter int SETTLE_CYCLES  = pmd_pkg::MEM_SETTLE_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output logic [7:0]       periph_clk_en,
    output logic [7:0]       periph_reset_hold,
    output logic [7:0]       periph_active,
    output logic [7:0]       pin_select_off,
    input  wire logic [7:0]  sfr_wr_req,
    output logic [7:0]       sfr_wr_allow,
    input  wire logic [63:0] sfr_rd_raw,
    output logic [63:0]      sfr_rd_data,
    output logic             periph_sysclk_gate,
    output logic             vref_off,
    output logic             clock_tuning_off,
    output logic             memory_access_off,
    output logic             pin_change_irq_off,
    output logic             timer_four_off,
    output logic             timer_two_off,
    output logic             timer_one_off,
    output logic             timer_zero_off,
    output logic             mem_user_access_en,
    output logic             mem_ctrl_wr_lock,
    output logic             mem_indirect_zero,
    output logic             mem_data_ready
);
    localparam int N  = pmd_pkg::NUM_MODULES;
    localparam int SW = $clog2(SETTLE_CYCLES + 1);
    localparam logic [SW-1:0] SETTLE_LOAD = SW'(SETTLE_CYCLES);

    // Refused at elaboration: a zero count would make the counters useless
    if (SETTLE_CYCLES < 1 || RELEASE_CYCLES < 1)
    begin : g_bad_params
        $error("module_disable: cycle counts must be at least one");
    end

    // Disable registers, only implemented bits are ever stored
    logic [7:0]    ctrl0;
    logic [7:0]    ctrl1;
    logic [7:0]    next_ctrl0;
    logic [7:0]    next_ctrl1;
    logic [SW-1:0] settle_cnt;
    logic [31:0]   rd_mux;
    logic [31:0]   status_word;
    logic          rd_q;
    logic          err_q;

    module_gate_if #(.N(N)) gi ();

    module_gate #(
        .N       (N),
        .RELEASE (RELEASE_CYCLES)
    ) u_gate (
        .pclk    (pclk),
        .presetn (presetn),
        .g       (gi)
    );

    // Bus decode
    wire setup_ph  = psel && !penable;
    wire access_ph = psel && penable;
    wire hit_ctrl0 = (paddr == pmd_pkg::OFF_CTRL0);
    wire hit_ctrl1 = (paddr == pmd_pkg::OFF_CTRL1);
    wire hit_stat  = (paddr == pmd_pkg::OFF_STATUS);
    wire hit_any   = hit_ctrl0 || hit_ctrl1 || hit_stat;
    wire bad_acc   = !hit_any || (pwrite && hit_stat);
    wire wr_lane0  = access_ph && pwrite && pstrb[0];
    wire wr_ctrl0  = wr_lane0 && hit_ctrl0;
    wire wr_ctrl1  = wr_lane0 && hit_ctrl1;

    // Masking on write keeps unimplemented bits at zero
    assign next_ctrl0 = wr_ctrl0 ? (pwdata[7:0] & pmd_pkg::CTRL0_MASK)
                                 : ctrl0;
    assign next_ctrl1 = wr_ctrl1 ? (pwdata[7:0] & pmd_pkg::CTRL1_MASK)
                                 : ctrl1;

    // Control registers: all modules on after any reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl0 <= pmd_pkg::CTRL_RESET;
            ctrl1 <= pmd_pkg::CTRL_RESET;
        end
        else
        begin
            ctrl0 <= next_ctrl0;
            ctrl1 <= next_ctrl1;
        end
    end

    // Field breakout, one named wire per disable bit
    assign periph_sysclk_gate = ctrl0[pmd_pkg::BIT_SYSCLK_GATE];
    assign vref_off           = ctrl0[pmd_pkg::BIT_VREF];
    assign clock_tuning_off   = ctrl0[pmd_pkg::BIT_CLK_TUNING];
    assign memory_access_off  = ctrl0[pmd_pkg::BIT_MEMORY];
    assign pin_change_irq_off = ctrl0[pmd_pkg::BIT_PIN_CHANGE];
    assign timer_four_off     = ctrl1[pmd_pkg::BIT_TIMER_FOUR];
    assign timer_two_off      = ctrl1[pmd_pkg::BIT_TIMER_TWO];
    assign timer_one_off      = ctrl1[pmd_pkg::BIT_TIMER_ONE];
    assign timer_zero_off     = ctrl1[pmd_pkg::BIT_TIMER_ZERO];

    // Module order on the gating vectors
    assign gi.off[pmd_pkg::IDX_PIN_CHANGE] = pin_change_irq_off;
    assign gi.off[pmd_pkg::IDX_MEMORY]     = memory_access_off;
    assign gi.off[pmd_pkg::IDX_CLK_TUNING] = clock_tuning_off;
    assign gi.off[pmd_pkg::IDX_VREF]       = vref_off;
    assign gi.off[pmd_pkg::IDX_TIMER_ZERO] = timer_zero_off;
    assign gi.off[pmd_pkg::IDX_TIMER_ONE]  = timer_one_off;
    assign gi.off[pmd_pkg::IDX_TIMER_TWO]  = timer_two_off;
    assign gi.off[pmd_pkg::IDX_TIMER_FOUR] = timer_four_off;

    // Module-facing outputs come from the gate slice, except pin_select_off, which is the disable vector itself
    assign gi.wr_req          = sfr_wr_req;
    assign gi.rd_raw          = sfr_rd_raw;
    assign periph_clk_en      = gi.clk_en;
    assign periph_reset_hold  = gi.reset_hold;
    assign periph_active      = ~gi.reset_hold;
    assign sfr_wr_allow       = gi.wr_allow;
    assign sfr_rd_data        = gi.rd_safe;
    assign pin_select_off     = gi.off;

    // Memory guard: user access needs the module out of reset
    assign mem_user_access_en =
        !gi.reset_hold[pmd_pkg::IDX_MEMORY];
    assign mem_ctrl_wr_lock   = memory_access_off;
    assign mem_indirect_zero  = memory_access_off;

    // Settle timer after memory re-enable; a hint to software, not a lock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            settle_cnt <= '0;
        else if (memory_access_off)
            settle_cnt <= SETTLE_LOAD;
        else if (settle_cnt != '0)
            settle_cnt <= settle_cnt - SW'(1);
    end

    assign mem_data_ready = !memory_access_off && (settle_cnt == '0);

    // Status word shows the block's own live state
    assign status_word = {22'h00_0000,
                          periph_sysclk_gate,
                          mem_data_ready,
                          periph_active};

    // Read selection; bits above the implemented ones read as zero
    assign rd_mux = hit_ctrl0 ? {24'h00_0000, ctrl0} :
                    hit_ctrl1 ? {24'h00_0000, ctrl1} :
                    hit_stat  ? status_word : 32'h0000_0000;

    // Read data is captured in setup so the access phase never waits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            rd_q   <= 1'b0;
            err_q  <= 1'b0;
        end
        else if (setup_ph)
        begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            rd_q   <= !pwrite;
            err_q  <= bad_acc;
        end
    end

    // Zero wait state: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = access_ph && err_q;

    // Bus write lands one edge after the access phase
    property p_wr_ctrl0;
        @(posedge pclk) disable iff (!presetn)
        wr_ctrl0 |=> ctrl0 == ($past(pwdata[7:0]) & pmd_pkg::CTRL0_MASK);
    endproperty
    a_wr_ctrl0: assert property (p_wr_ctrl0)
        else $error("first control register write not stored masked");

    property p_unimpl;
        @(posedge pclk) disable iff (!presetn)
        access_ph && !pwrite && rd_q && (hit_ctrl0 || hit_ctrl1)
            |-> prdata[31:8] == 24'h00_0000
                && (prdata[7:0] & ~(hit_ctrl0 ? pmd_pkg::CTRL0_MASK
                                              : pmd_pkg::CTRL1_MASK))
                   == 8'h00;
    endproperty
    a_unimpl: assert property (p_unimpl)
        else $error("unimplemented bits read as one");

    sequence s_timer_write;
        wr_ctrl1 && pwdata[pmd_pkg::BIT_TIMER_FOUR];
    endsequence

    property p_timer_off;
        @(posedge pclk) disable iff (!presetn)
        s_timer_write |=> timer_four_off && !periph_clk_en[
            pmd_pkg::IDX_TIMER_FOUR] && pin_select_off[
            pmd_pkg::IDX_TIMER_FOUR];
    endproperty
    a_timer_off: assert property (p_timer_off)
        else $error("timer four not cut after disable write");

    property p_sysclk;
        @(posedge pclk) disable iff (!presetn)
        wr_ctrl0 |=> periph_sysclk_gate
            == $past(pwdata[pmd_pkg::BIT_SYSCLK_GATE]);
    endproperty
    a_sysclk: assert property (p_sysclk)
        else $error("system clock gate does not follow its bit");

    property p_mem_lock;
        @(posedge pclk) disable iff (!presetn)
        memory_access_off |-> mem_ctrl_wr_lock && mem_indirect_zero
            && !mem_user_access_en && !mem_data_ready;
    endproperty
    a_mem_lock: assert property (p_mem_lock)
        else $error("memory reachable while disabled");

    sequence s_mem_back;
        $fell(memory_access_off) ##1 (!memory_access_off)[*8];
    endsequence

    property p_settle_min;
        @(posedge pclk) disable iff (!presetn)
        s_mem_back |-> !mem_data_ready;
    endproperty
    a_settle_min: assert property (p_settle_min)
        else $error("memory ready too soon after enable");

    property p_settle_max;
        @(posedge pclk) disable iff (!presetn)
        $fell(memory_access_off)
            |-> ##[1:300] (mem_data_ready || memory_access_off);
    endproperty
    a_settle_max: assert property (p_settle_max)
        else $error("memory never became ready");

    property p_reset_hold_bus;
        @(posedge pclk) disable iff (!presetn)
        periph_reset_hold[pmd_pkg::IDX_VREF]
            |-> !sfr_wr_allow[pmd_pkg::IDX_VREF];
    endproperty
    a_reset_hold_bus: assert property (p_reset_hold_bus)
        else $error("write passed to a held module");

    property p_slverr;
        @(posedge pclk) disable iff (!presetn)
        access_ph && !hit_any |-> pslverr && pready;
    endproperty
    a_slverr: assert property (p_slverr)
        else $error("unmapped access not flagged");
endmodule : module_disable

// ---- tb/test_peripheral_module_disable.sv ----
// Self-checking testbench for the peripheral module disable block
module test_peripheral_module_disable;
    timeunit 1ns;
    timeprecision 100ps;

    // Short settle count keeps the memory wait brief
    localparam int SETTLE = 20;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [7:0]  clk_en, hold, active, pin_off, wr_req, wr_allow, m0, m1;
    logic [63:0] rd_raw, rd_data;
    logic [8:0]  flags;
    logic [2:0]  mem;
    logic        mem_ready;
    int          errors, n_tests;

    module_disable #(.RELEASE_CYCLES(4), .SETTLE_CYCLES(SETTLE)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .periph_clk_en(clk_en), .periph_reset_hold(hold),
        .periph_active(active), .pin_select_off(pin_off),
        .sfr_wr_req(wr_req), .sfr_wr_allow(wr_allow),
        .sfr_rd_raw(rd_raw), .sfr_rd_data(rd_data),
        .periph_sysclk_gate(flags[8]), .vref_off(flags[7]),
        .clock_tuning_off(flags[6]), .memory_access_off(flags[5]),
        .pin_change_irq_off(flags[4]), .timer_four_off(flags[3]),
        .timer_two_off(flags[2]), .timer_one_off(flags[1]),
        .timer_zero_off(flags[0]), .mem_user_access_en(mem[2]),
        .mem_ctrl_wr_lock(mem[1]), .mem_indirect_zero(mem[0]),
        .mem_data_ready(mem_ready));

    // Expected disable vector in gating order
    function automatic logic [7:0] offs();
        return {m1[4], m1[2], m1[1], m1[0], m0[6], m0[5], m0[2], m0[0]};
    endfunction : offs

    // One comparison, counted
    task automatic chk(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : chk

    // Counts, verdict and end of run
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    // APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
        begin
            errors++;
            give_verdict();
        end
        else
        begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    // Write and mirror into the model; only byte lane 0 counts
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        apb(1'b1, a, d, s);
        if (s[0] && a == 12'h000)
            m0 = d[7:0] & 8'hE5;
        if (s[0] && a == 12'h004)
            m1 = d[7:0] & 8'h17;
        #1;
    endtask : wr

    // Read both control registers back
    task automatic rd_regs();
        apb(1'b0, 12'h000, 32'h0000_0000, 4'h0);
        chk("ctrl0", rd, {24'h00_0000, m0});
        chk("ctrl0 err", err, 1'b0);
        apb(1'b0, 12'h004, 32'h0000_0000, 4'h0);
        chk("ctrl1", rd, {24'h00_0000, m1});
    endtask : rd_regs

    // Steady-state outputs once any release window is over
    task automatic steady();
        logic [7:0]  o;
        logic [63:0] e;
        logic [8:0]  f;
        o = offs();
        f = {m0[7], m0[6], m0[5], m0[2], m0[0], m1[4], m1[2], m1[1], m1[0]};
        @(posedge pclk);
        wr_req <= 8'($urandom);
        rd_raw <= {$urandom, $urandom};
        repeat (6) @(posedge pclk);
        #1;
        for (int i = 0; i < 8; i++)
            e[8*i +: 8] = o[i] ? 8'h00 : rd_raw[8*i +: 8];
        chk("clk_en", clk_en, 8'(~o));
        chk("reset_hold", hold, o);
        chk("active", active, 8'(~o));
        chk("pin_select_off", pin_off, o);
        chk("wr_allow", wr_allow, 8'(wr_req & ~o));
        chk("rd_data", rd_data, e);
        chk("flags", flags, f);
        chk("memory", mem, {~m0[2], m0[2], m0[2]});
    endtask : steady

    // Free-running system clock
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // Watchdog against a hang anywhere
    initial
    begin
        #200000;
        errors++;
        give_verdict();
    end

    // Main sequence
    initial
    begin
        int          pos[8];
        logic [11:0] a;
        int          n;
        pos = '{0, 2, 5, 6, 0, 1, 2, 4};
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        wr_req = 8'h00;
        rd_raw = 64'h0000_0000_0000_0000;
        errors = 0;
        n_tests = 0;
        m0 = 8'h00;
        m1 = 8'h00;
        void'($urandom(76));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd_regs();
        steady();
        // Random writes, some with lane 0 strobe off
        for (int i = 0; i < 12; i++)
        begin
            wr(($urandom % 2) ? 12'h004 : 12'h000, $urandom, 4'($urandom));
            rd_regs();
            steady();
        end
        // Each module: set, clear, then one instruction of reset hold
        wr(12'h000, 32'h0000_0000, 4'hF);
        wr(12'h004, 32'h0000_0000, 4'hF);
        repeat (6) @(posedge pclk);
        wr_req <= 8'hFF;
        for (int i = 0; i < 8; i++)
        begin
            a = (i < 4) ? 12'h000 : 12'h004;
            wr(a, 32'h1 << pos[i], 4'h1);
            chk("hold on set", hold[i], 1'b1);
            chk("gate on set", clk_en[i], 1'b0);
            chk("write blocked", wr_allow[i], 1'b0);
            wr(a, 32'h0000_0000, 4'h1);
            chk("clock back", clk_en[i], 1'b1);
            chk("hold after clear", hold[i], 1'b1);
            // No register access for one instruction after the clear
            repeat (3) @(posedge pclk);
            #1;
            chk("hold last cycle", hold[i], 1'b1);
            @(posedge pclk);
            #1;
            chk("hold released", hold[i], 1'b0);
            chk("write allowed", wr_allow[i], 1'b1);
        end
        // Memory access off, then settle before data is ready
        wr(12'h000, 32'h0000_0004, 4'h1);
        repeat (4) @(posedge pclk);
        #1;
        chk("mem ready off", mem_ready, 1'b0);
        wr(12'h000, 32'h0000_0000, 4'h1);
        n = 0;
        while (mem_ready !== 1'b1 && n < 300)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        // Ready exactly one settle count after the clearing edge
        chk("settle", n, SETTLE);
        apb(1'b0, 12'h008, 32'h0000_0000, 4'h0);
        chk("status", rd, {22'h0, m0[7], 1'b1, ~offs()});
        // Unmapped and read-only places refuse and change nothing
        apb(1'b0, 12'h00C, 32'h0000_0000, 4'h0);
        chk("unmapped err", err, 1'b1);
        chk("unmapped data", rd, 32'h0000_0000);
        wr(12'h008, 32'hFFFF_FFFF, 4'hF);
        chk("status write err", err, 1'b1);
        wr(12'h010, 32'h0000_00FF, 4'hF);
        chk("unmapped write err", err, 1'b1);
        rd_regs();
        // Reset in mid-run returns every module to enabled
        wr(12'h000, 32'hFFFF_FFFF, 4'hF);
        wr(12'h004, 32'hFFFF_FFFF, 4'hF);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        m0 = 8'h00;
        m1 = 8'h00;
        #1;
        chk("hold after reset", hold, 8'h00);
        rd_regs();
        steady();
        give_verdict();
    end
endmodule : test_peripheral_module_disable
